// ### caac_pkg.sv
// Package of constants and types for the channel averaging and correction path.
package caac_pkg;

  // ---------------------------------------------------------------------------
  // Widths and register map
  // ---------------------------------------------------------------------------
  localparam int unsigned CAAC_DATA_W = 24;
  localparam int unsigned CAAC_OFS_W = 23;
  localparam int unsigned CAAC_GAIN_W = 20;
  localparam int unsigned CAAC_NCH = 4;
  localparam int unsigned CAAC_ADDR_W = 7;

  localparam logic [6:0] CAAC_IF_CFG_ADDR = 7'h12;
  // Per-channel windows: control is one byte per channel, coefficients are base plus four bytes per channel.
  localparam logic [6:0] CAAC_CTRL_BASE = 7'h20;
  localparam logic [6:0] CAAC_OFS_BASE = 7'h24;
  localparam logic [6:0] CAAC_GAIN_BASE = 7'h34;
  localparam logic [6:0] CAAC_BLK_SPAN = 7'h10;

  // Interface format field and averaging option field positions.
  localparam int unsigned CAAC_FMT_LSB = 0;
  localparam int unsigned CAAC_AVG_LSB = 2;
  localparam logic [1:0] CAAC_FMT_AVG = 2'h3;
  localparam logic [1:0] CAAC_AVG_FOUR = 2'h0;
  localparam logic [1:0] CAAC_AVG_TWO = 2'h1;
  localparam logic [7:0] CAAC_IF_CFG_RST = 8'h00;

  // Per-channel control byte bits.
  localparam int unsigned CAAC_OFS_EN_BIT = 0;
  localparam int unsigned CAAC_GAIN_SEL_BIT = 1;

  // Gain of unity is mid-code; one count is 2^-20, about 0.95 ppm.
  localparam int unsigned CAAC_GAIN_FRAC = 20;
  localparam logic [19:0] CAAC_GAIN_UNITY = 20'h80000;
  localparam logic [19:0] CAAC_GAIN_FACTORY = 20'h80000;
  localparam logic [22:0] CAAC_OFS_FACTORY = 23'h000000;
  localparam int unsigned CAAC_OFS_SHIFT = 1;

  typedef logic signed [CAAC_DATA_W-1:0] caac_sample_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } caac_reg_req_s;

  typedef struct packed {
    logic       pin_mode;
    logic       fmt_high;
    logic       fmt_low;
  } caac_mode_s;

endpackage

// ### caac_chan_corr.sv
// One channel of offset and gain correction with saturation.
`timescale 1ns/1ps
module caac_chan_corr (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic valid_i,
  input wire caac_pkg::caac_sample_t sample_i,
  input wire logic [caac_pkg::CAAC_OFS_W-1:0] offset_i,
  input wire logic [caac_pkg::CAAC_GAIN_W-1:0] gain_i,
  input wire logic offset_en_i,
  input wire logic gain_en_i,
  output caac_pkg::caac_sample_t sample_o
);
  import caac_pkg::*;

  typedef struct packed {
    caac_sample_t smp;
  } caac_corr_state_s;

  localparam int unsigned PW = CAAC_DATA_W + CAAC_GAIN_W + 2;
  localparam logic signed [PW-1:0] MAXV = PW'((1 <<< (CAAC_DATA_W-1)) - 1);
  localparam logic signed [PW-1:0] MINV = -PW'(1 <<< (CAAC_DATA_W-1));

  caac_corr_state_s state_reg;
  caac_corr_state_s state_next;
  logic signed [PW-1:0] acc;
  logic signed [PW-1:0] scaled;
  logic signed [CAAC_GAIN_W+1:0] gain_mul;

  always_comb begin
    state_next = state_reg;
    // The code is biased by half scale, so mid-code multiplies by one.
    gain_mul = $signed({2'b00, gain_i} + {2'b00, CAAC_GAIN_UNITY});
    acc = PW'(sample_i);
    if (offset_en_i) begin
      acc = acc + (PW'($signed(offset_i)) <<< CAAC_OFS_SHIFT);
    end
    scaled = acc;
    if (gain_en_i) begin
      // Gain code is unsigned with unity at mid-code, giving 0.5x to 1.5x.
      scaled = (acc * gain_mul) >>> CAAC_GAIN_FRAC;
    end
    if (valid_i) begin
      if (scaled > MAXV) begin
        state_next.smp = MAXV[CAAC_DATA_W-1:0];
      end else if (scaled < MINV) begin
        state_next.smp = MINV[CAAC_DATA_W-1:0];
      end else begin
        state_next.smp = scaled[CAAC_DATA_W-1:0];
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sample_o = state_reg.smp;
endmodule

// ### caac_top.sv
// Channel correction and averaging datapath with its register file.
`timescale 1ns/1ps
module caac_top #(
  parameter int unsigned NCH = caac_pkg::CAAC_NCH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire caac_pkg::caac_reg_req_s reg_req_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic pin_control_mode_i,
  input wire logic format_select_low_pin_i,
  input wire logic format_select_high_pin_i,
  input wire logic data_interface_reset_bit_i,
  input wire logic in_valid_i,
  input wire caac_pkg::caac_sample_t [caac_pkg::CAAC_NCH-1:0] in_data_i,
  output logic out_valid_o,
  output caac_pkg::caac_sample_t [caac_pkg::CAAC_NCH-1:0] out_data_o,
  output logic [caac_pkg::CAAC_NCH-1:0] out_enable_o,
  output logic daisy_input_active_o,
  output logic averaging_active_o
);
  import caac_pkg::*;

  // ---------------------------------------------------------------------------
  // Elaboration check
  // ---------------------------------------------------------------------------
  if (NCH != CAAC_NCH) begin : g_bad_nch
    $error("caac_top serves exactly four channels");
  end

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    CAAC_MODE_NONE = 3'b001,
    CAAC_MODE_TWO = 3'b010,
    CAAC_MODE_FOUR = 3'b100
  } caac_avg_e;

  typedef struct packed {
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [7:0] if_cfg;
    logic [CAAC_NCH-1:0][1:0] ctrl;
    logic [CAAC_NCH-1:0][CAAC_OFS_W-1:0] ofs;
    logic [CAAC_NCH-1:0][CAAC_GAIN_W-1:0] gain;
    logic [7:0] rdata;
    logic rvalid;
    logic stage_v;
    logic out_v;
    logic avg;
    caac_sample_t [CAAC_NCH-1:0] out;
    logic [CAAC_NCH-1:0] oen;
    logic daisy;
  } caac_state_s;

  caac_state_s state_reg;
  caac_state_s state_next;
  caac_state_s state_rst;

  caac_sample_t [CAAC_NCH-1:0] corr;
  caac_mode_s mode_pins;
  logic cal_allowed;
  logic [6:0] rel;
  logic [1:0] ch;
  logic [1:0] bsel;
  logic [CAAC_DATA_W+1:0] sum4;
  logic [CAAC_DATA_W:0] sum01;
  logic [CAAC_DATA_W:0] sum23;
  caac_avg_e mode_sel;

  // ---------------------------------------------------------------------------
  // Per-channel correction
  // ---------------------------------------------------------------------------
  // Correction is gated off in pin mode so that stored values cannot leak.
  assign cal_allowed = ~mode_pins.pin_mode;

  for (genvar i = 0; i < CAAC_NCH; i++) begin : g_ch
    caac_chan_corr u_corr (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .valid_i(in_valid_i),
      .sample_i(in_data_i[i]),
      .offset_i(state_reg.ofs[i]),
      .gain_i(state_reg.gain[i]),
      .offset_en_i(cal_allowed & state_reg.ctrl[i][CAAC_OFS_EN_BIT]),
      .gain_en_i(cal_allowed & state_reg.ctrl[i][CAAC_GAIN_SEL_BIT]),
      .sample_o(corr[i])
    );
  end

  assign mode_pins = '{pin_mode: state_reg.pin_s2[0],
                       fmt_high: state_reg.pin_s2[2],
                       fmt_low: state_reg.pin_s2[1]};

  always_comb begin
    state_rst = '0;
    state_rst.if_cfg = CAAC_IF_CFG_RST;
    for (int k = 0; k < CAAC_NCH; k++) begin
      state_rst.ofs[k] = CAAC_OFS_FACTORY;
      state_rst.gain[k] = CAAC_GAIN_FACTORY;
    end
  end

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    state_next.pin_s1 = {format_select_high_pin_i, format_select_low_pin_i,
                         pin_control_mode_i};
    state_next.pin_s2 = state_reg.pin_s1;

    // Register access: one byte per address, coefficients little endian.
    rel = 7'h00;
    ch = 2'h0;
    bsel = 2'h0;
    state_next.rvalid = reg_req_i.rd;
    state_next.rdata = 8'h00;
    if (reg_req_i.addr == CAAC_IF_CFG_ADDR) begin
      if (reg_req_i.wr) begin
        state_next.if_cfg = reg_req_i.wdata;
      end
      state_next.rdata = state_reg.if_cfg;
    end else if (reg_req_i.addr >= CAAC_CTRL_BASE &&
                 reg_req_i.addr < CAAC_OFS_BASE) begin
      ch = reg_req_i.addr[1:0];
      if (reg_req_i.wr) begin
        state_next.ctrl[ch] = reg_req_i.wdata[1:0];
      end
      state_next.rdata = {6'h00, state_reg.ctrl[ch]};
    end else if (reg_req_i.addr >= CAAC_OFS_BASE &&
                 reg_req_i.addr < CAAC_OFS_BASE + CAAC_BLK_SPAN) begin
      rel = reg_req_i.addr - CAAC_OFS_BASE;
      ch = rel[3:2];
      bsel = rel[1:0];
      case (bsel)
        2'h0: begin
          if (reg_req_i.wr) state_next.ofs[ch][7:0] = reg_req_i.wdata;
          state_next.rdata = state_reg.ofs[ch][7:0];
        end
        2'h1: begin
          if (reg_req_i.wr) state_next.ofs[ch][15:8] = reg_req_i.wdata;
          state_next.rdata = state_reg.ofs[ch][15:8];
        end
        2'h2: begin
          if (reg_req_i.wr) state_next.ofs[ch][22:16] = reg_req_i.wdata[6:0];
          state_next.rdata = {1'b0, state_reg.ofs[ch][22:16]};
        end
        default: state_next.rdata = 8'h00;
      endcase
    end else if (reg_req_i.addr >= CAAC_GAIN_BASE &&
                 reg_req_i.addr < CAAC_GAIN_BASE + CAAC_BLK_SPAN) begin
      rel = reg_req_i.addr - CAAC_GAIN_BASE;
      ch = rel[3:2];
      bsel = rel[1:0];
      case (bsel)
        2'h0: begin
          if (reg_req_i.wr) state_next.gain[ch][7:0] = reg_req_i.wdata;
          state_next.rdata = state_reg.gain[ch][7:0];
        end
        2'h1: begin
          if (reg_req_i.wr) state_next.gain[ch][15:8] = reg_req_i.wdata;
          state_next.rdata = state_reg.gain[ch][15:8];
        end
        2'h2: begin
          if (reg_req_i.wr) state_next.gain[ch][19:16] = reg_req_i.wdata[3:0];
          state_next.rdata = {4'h0, state_reg.gain[ch][19:16]};
        end
        default: state_next.rdata = 8'h00;
      endcase
    end

    // Mode selection.
    mode_sel = CAAC_MODE_NONE;
    if (mode_pins.pin_mode) begin
      if (mode_pins.fmt_high && mode_pins.fmt_low) begin
        mode_sel = CAAC_MODE_FOUR;
      end
    end else if (state_reg.if_cfg[CAAC_FMT_LSB +: 2] == CAAC_FMT_AVG) begin
      case (state_reg.if_cfg[CAAC_AVG_LSB +: 2])
        CAAC_AVG_FOUR: mode_sel = CAAC_MODE_FOUR;
        CAAC_AVG_TWO: mode_sel = CAAC_MODE_TWO;
        default: mode_sel = CAAC_MODE_NONE;
      endcase
    end

    // Averaging follows the corrected samples one cycle later.
    state_next.stage_v = in_valid_i;
    state_next.out_v = state_reg.stage_v;
    sum01 = {corr[0][CAAC_DATA_W-1], corr[0]} + {corr[1][CAAC_DATA_W-1], corr[1]};
    sum23 = {corr[2][CAAC_DATA_W-1], corr[2]} + {corr[3][CAAC_DATA_W-1], corr[3]};
    sum4 = {sum01[CAAC_DATA_W], sum01} + {sum23[CAAC_DATA_W], sum23};
    // A flushed sample must leave the held output data untouched.
    if (state_reg.stage_v && !data_interface_reset_bit_i) begin
      state_next.avg = (mode_sel != CAAC_MODE_NONE);
      state_next.daisy = 1'b0;
      case (mode_sel)
        CAAC_MODE_FOUR: begin
          state_next.out = '0;
          state_next.out[0] = sum4[CAAC_DATA_W+1:2];
          state_next.oen = 4'b0001;
          state_next.daisy = 1'b1;
        end
        CAAC_MODE_TWO: begin
          state_next.out = '0;
          state_next.out[0] = sum01[CAAC_DATA_W:1];
          state_next.out[1] = sum23[CAAC_DATA_W:1];
          state_next.oen = 4'b0011;
        end
        CAAC_MODE_NONE: begin
          state_next.out = corr;
          state_next.oen = 4'b1111;
        end
        default: begin
          state_next.out = corr;
          state_next.oen = 4'b1111;
        end
      endcase
    end

    // An interface reset drops the pending sample, not the coefficients.
    if (data_interface_reset_bit_i) begin
      state_next.stage_v = 1'b0;
      state_next.out_v = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_reg <= state_rst;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------------------
  assign reg_rdata_o = state_reg.rdata;
  assign reg_rvalid_o = state_reg.rvalid;
  assign out_valid_o = state_reg.out_v;
  assign out_data_o = state_reg.out;
  assign out_enable_o = state_reg.oen;
  assign daisy_input_active_o = state_reg.daisy;
  assign averaging_active_o = state_reg.avg;
endmodule

// ### caac_monitor.sv
// Port checker for the correction and averaging datapath.
`timescale 1ns/1ps
module caac_monitor #(
  parameter int unsigned NCH = caac_pkg::CAAC_NCH
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire caac_pkg::caac_reg_req_s reg_req_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic data_interface_reset_bit_i,
  input wire logic in_valid_i,
  input wire logic out_valid_o,
  input wire caac_pkg::caac_sample_t [caac_pkg::CAAC_NCH-1:0] out_data_o,
  input wire logic [caac_pkg::CAAC_NCH-1:0] out_enable_o,
  input wire logic daisy_input_active_o,
  input wire logic averaging_active_o
);
  import caac_pkg::*;
  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  read_answer_a: assert property (
    reg_req_i.rd |=> reg_rvalid_o) else $error("read not answered");
  stray_answer_a: assert property (
    !reg_req_i.rd |=> !reg_rvalid_o) else $error("unrequested answer");
  unmapped_zero_a: assert property (
    reg_req_i.rd && reg_req_i.addr == 7'h7F |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  out_latency_a: assert property (
    (in_valid_i && !data_interface_reset_bit_i) ##1
    !data_interface_reset_bit_i ##1 !data_interface_reset_bit_i
    |-> ##[0:1] out_valid_o) else $error("sample not delivered");
  flush_drop_a: assert property (
    (data_interface_reset_bit_i && !in_valid_i) [*3] |=> !out_valid_o)
    else $error("sample survived interface reset");
  four_avg_a: assert property (
    daisy_input_active_o |-> averaging_active_o)
    else $error("daisy input without averaging");
  daisy_enables_a: assert property (
    daisy_input_active_o |-> out_enable_o == 4'h1)
    else $error("wrong outputs enabled in four-to-one");
  single_output_a: assert property (
    out_valid_o && daisy_input_active_o |-> out_data_o[1] == '0 &&
    out_data_o[2] == '0 && out_data_o[3] == '0)
    else $error("extra channel data in four-to-one");
  reset_clear_a: assert property (
    $fell(reset_i) |-> !out_valid_o && !averaging_active_o &&
    out_enable_o == '0) else $error("outputs not cleared by reset");
  data_hold_a: assert property (
    !out_valid_o |-> $stable(out_data_o)) else $error("data changed");
endmodule

// ### caac_host_model.sv
// Host model that drives register accesses and the interface reset.
`timescale 1ns/1ps
module caac_host_model (
  input wire logic clk_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  output caac_pkg::caac_reg_req_s reg_req_o,
  output logic dif_reset_o
);
  import caac_pkg::*;
  initial begin
    reg_req_o = '0;
    dif_reset_o = 1'b0;
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_req_o <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    reg_req_o <= '0;
  endtask
  // The answer is taken at the edge where its valid is sampled high.
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(posedge clk_i);
    reg_req_o <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    reg_req_o <= '0;
    @(posedge clk_i);
    d = (reg_rvalid_o === 1'b1) ? reg_rdata_o : 'x;
  endtask
  // Called just after an edge; one level held for n cycles.
  task automatic flush(input int n);
    dif_reset_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    dif_reset_o <= 1'b0;
  endtask
endmodule

// ### test_channel_average_and_calibration.sv
// Self-checking bench for the correction and averaging datapath.
`timescale 1ns/1ps
module test_channel_average_and_calibration;
  import caac_pkg::*;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  caac_reg_req_s req;
  logic [7:0] rdata, rb;
  logic rvalid, out_valid, daisy, avg_on, dif;
  logic pin_mode = 1'b0;
  logic fmt_lo = 1'b0;
  logic fmt_hi = 1'b0;
  logic in_valid = 1'b0;
  caac_sample_t [CAAC_NCH-1:0] in_data = '0;
  caac_sample_t [CAAC_NCH-1:0] out_data;
  logic [CAAC_NCH-1:0] out_en;
  int bad_count = 0;
  int cmp_count = 0;

  initial begin
    forever #5 clk_i = ~clk_i;
  end

  caac_host_model i_host (.clk_i, .reg_rdata_o(rdata),
    .reg_rvalid_o(rvalid), .reg_req_o(req), .dif_reset_o(dif));
  caac_top #(.NCH(CAAC_NCH)) i_dut (.clk_i, .reset_i, .reg_req_i(req),
    .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
    .pin_control_mode_i(pin_mode), .format_select_low_pin_i(fmt_lo),
    .format_select_high_pin_i(fmt_hi), .data_interface_reset_bit_i(dif),
    .in_valid_i(in_valid), .in_data_i(in_data), .out_valid_o(out_valid),
    .out_data_o(out_data), .out_enable_o(out_en),
    .daisy_input_active_o(daisy), .averaging_active_o(avg_on));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Leaves the caller at the edge where the result is sampled valid.
  task automatic send(input int a, input int b, input int c, input int d);
    @(posedge clk_i);
    in_data <= {24'(d), 24'(c), 24'(b), 24'(a)};
    in_valid <= 1'b1;
    @(posedge clk_i);
    in_valid <= 1'b0;
    for (int i = 0; i < 8 && out_valid !== 1'b1; i++) begin
      @(posedge clk_i);
    end
    chk(24'(out_valid), 24'h000001);
  endtask
  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    i_host.rd(a, rb);
    chk(24'(rb), 24'(exp));
  endtask

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(7'h12, 8'h00);
    rd_chk(7'h36, 8'h08);
    rd_chk(7'h7F, 8'h00);
    send(1000, 4000, 300, -8);
    chk(out_data[0], 24'(1000));
    chk(out_data[1], 24'(4000));
    i_host.wr(7'h24, 8'h64);
    i_host.wr(7'h20, 8'h01);
    i_host.wr(7'h2C, 8'hCE);
    i_host.wr(7'h2D, 8'hFF);
    i_host.wr(7'h2E, 8'h7F);
    i_host.wr(7'h22, 8'h01);
    i_host.wr(7'h3A, 8'h0C);
    i_host.wr(7'h21, 8'h02);
    rd_chk(7'h3A, 8'h0C);
    send(1000, 4000, 300, -8);
    chk(out_data[0], 24'(1000 + 2 * 100));
    chk(out_data[1], 24'(4000 + 1000));
    chk(out_data[2], 24'(300 - 2 * 50));
    chk(out_data[3], 24'(-8));
    i_host.wr(7'h12, 8'h07);
    send(1000, 4000, 300, -8);
    chk(out_data[0], 24'((1200 + 5000) / 2));
    chk(out_data[1], 24'((200 - 8) / 2));
    chk(24'(avg_on), 24'h000001);
    i_host.wr(7'h12, 8'h03);
    send(1000, 4000, 300, -8);
    chk(out_data[0], 24'((1200 + 5000 + 200 - 8) / 4));
    chk(24'({daisy, out_en}), 24'h000011);
    i_host.wr(7'h12, 8'h0B);
    send(1000, 4000, 300, -8);
    chk(24'({avg_on, daisy}), 24'h000000);
    chk(out_data[0], 24'(1200));
    pin_mode <= 1'b1;
    fmt_lo <= 1'b1;
    fmt_hi <= 1'b1;
    repeat (4) @(posedge clk_i);
    send(1000, 4000, 300, -8);
    chk(out_data[0], 24'((1000 + 4000 + 300 - 8) / 4));
    chk(24'({daisy, out_en}), 24'h000011);
    fmt_lo <= 1'b0;
    repeat (4) @(posedge clk_i);
    send(1000, 4000, 300, -8);
    chk(out_data[1], 24'(4000));
    chk(24'(avg_on), 24'h000000);
    pin_mode <= 1'b0;
    @(posedge clk_i);
    in_valid <= 1'b1;
    @(posedge clk_i);
    in_valid <= 1'b0;
    fork
      i_host.flush(4);
      repeat (4) begin
        @(posedge clk_i);
        chk(24'(out_valid), 24'h000000);
      end
    join
    reset_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd_chk(7'h24, 8'h00);
    rd_chk(7'h3A, 8'h08);
    tally_and_finish();
  end

  // A hang is cut well past the hundred or so cycles the tests need.
  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    tally_and_finish();
  end
endmodule

bind caac_top caac_monitor #(.NCH(NCH)) i_mon (.clk_i, .reset_i,
  .reg_req_i, .reg_rdata_o, .reg_rvalid_o, .data_interface_reset_bit_i,
  .in_valid_i, .out_valid_o, .out_data_o, .out_enable_o,
  .daisy_input_active_o, .averaging_active_o);
